// >>> hw/cdl_defines.vh
`ifndef CDL_DEFINES_VH
`define CDL_DEFINES_VH

// ****************************************
// Clock and slow tick
// ****************************************
`define CDL_CLK_PERIOD_NS   4
`define CDL_TICK_PERIOD_NS  1000000
`define CDL_TICK_CYCLES     (`CDL_TICK_PERIOD_NS / `CDL_CLK_PERIOD_NS)
`define CDL_TICK_CNT_W      18

// ****************************************
// Debounce periods, in milliseconds
// ****************************************
// Sized to the debounce counter so the tick counts fit it exactly
`define CDL_DB_CHG_DET_MS   10'h064
`define CDL_DB_BATTERY_VOLTAGE_NODE_FAST_MS 10'h020
`define CDL_DB_BATTERY_VOLTAGE_NODE_SLOW_MS 10'h3e8
`define CDL_DB_BMIN_FALL_MS 10'h3e8
`define CDL_DB_CCCV_MS      10'h064
`define CDL_DB_EOC_MS       10'h001
`define CDL_TICK_MS         10'h001
`define CDL_DB_CNT_W        10
`define CDL_DB_NONE         10'h000

// ****************************************
// Debounce channel indices
// ****************************************
`define CDL_CH_CHG_DET      0
`define CDL_CH_BMIN_FAST    1
`define CDL_CH_BMIN_SLOW    2
`define CDL_CH_BON_FAST     3
`define CDL_CH_BON_SLOW     4
`define CDL_CH_CCCV         5
`define CDL_CH_EOC          6
`define CDL_NUM_CH          7

// ****************************************
// Charge current setting codes
// ****************************************
`define CDL_ICHG_LOWEST     4'h0
`define CDL_ICHG_LOW        4'h1

// ****************************************
// Register map (byte addresses)
// ****************************************
`define CDL_ADDR_W          4
`define CDL_REG_CTRL        4'h0
`define CDL_REG_STATUS      4'h4
`define CDL_REG_EVENT       4'h8
`define CDL_CTRL_RESET      8'h00

// CTRL fields
`define CDL_CTRL_FORCE_BIT  0
`define CDL_CTRL_SWCHG_BIT  1
`define CDL_CTRL_ICHG_LSB   4
`define CDL_CTRL_ICHG_MSB   7

// EVENT fields
`define CDL_EVT_CCCV_BIT    0
`define CDL_EVT_EOC_BIT     1

// AXI responses
`define CDL_RESP_OKAY       2'h0
`define CDL_RESP_SLVERR     2'h2

`endif

// >>> hw/cdl_charger_detect.v
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - Insertion needs valid and presence both high at low settings or idle
// - Low settings or idle: valid and presence
// - Other settings: presence or current, ignore valid
// - Charger detect debounced 100 ms, both edges
// - Battery levels: 32 ms and 1 s rising
// - Battery minimum falling edge 1 s, both outputs
// - Separate fast and slow battery outputs
// - Events on transition and end-of-charge crossings
// - Thermistor in range between both thresholds
// - LED on with standalone charging, stays controlled
// - LED off at end of charge unless forced
// - Force bit: 0 automatic, 1 forced on
// - Software charging: LED follows force bit only
`include "cdl_defines.vh"

module cdl_charger_detect #(
  parameter TICK_CYCLES = `CDL_TICK_CYCLES
) (
  // Clock and reset
  input  wire                      aclk,
  input  wire                      aresetn,
  // AXI4-Lite write address
  input  wire                      s_axi_awvalid,
  output wire                      s_axi_awready,
  input  wire [`CDL_ADDR_W-1:0]    s_axi_awaddr,
  // AXI4-Lite write data
  input  wire                      s_axi_wvalid,
  output wire                      s_axi_wready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output wire                      s_axi_bvalid,
  input  wire                      s_axi_bready,
  output wire [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire                      s_axi_arvalid,
  output wire                      s_axi_arready,
  input  wire [`CDL_ADDR_W-1:0]    s_axi_araddr,
  // AXI4-Lite read data
  output wire                      s_axi_rvalid,
  input  wire                      s_axi_rready,
  output wire [31:0]               s_axi_rdata,
  output wire [1:0]                s_axi_rresp,
  // Raw comparators
  input  wire                      charger_valid_cmp,
  input  wire                      charger_presence_cmp,
  input  wire                      end_of_charge_current,
  input  wire                      battery_minimum_level,
  input  wire                      battery_operating_level,
  input  wire                      cc_to_cv_transition_level,
  input  wire                      thermistor_below_low_cmp,
  input  wire                      thermistor_above_high_cmp,
  // Charger state machine
  input  wire                      charging_active,
  input  wire                      charge_sm_running,
  input  wire                      charge_sm_done,
  // Debounced status
  output wire                      charger_detected,
  output wire                      battery_minimum_fast,
  output wire                      battery_minimum_slow,
  output wire                      battery_operating_fast,
  output wire                      battery_operating_slow,
  output wire                      cc_to_cv_debounced,
  output wire                      end_of_charge_debounced,
  output wire                      thermistor_in_range,
  // Events and LED
  output wire                      transition_interrupt,
  output wire                      end_of_charge_interrupt,
  output wire                      charge_indicator_sink
);

  // ****************************************
  // Slow tick
  // ****************************************
  reg  [`CDL_TICK_CNT_W-1:0] tick_cnt_q;
  reg                        tick_q;
  wire [`CDL_TICK_CNT_W-1:0] tick_last;
  wire [31:0]                tick_last_full;

  assign tick_last_full = TICK_CYCLES - 1;
  assign tick_last      = tick_last_full[`CDL_TICK_CNT_W-1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= {`CDL_TICK_CNT_W{1'b0}};
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == tick_last) begin
      tick_cnt_q <= {`CDL_TICK_CNT_W{1'b0}};
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // ****************************************
  // Control register state
  // ****************************************
  reg        force_on_q;
  reg        sw_charge_q;
  reg  [3:0] ichg_q;
  reg  [1:0] event_q;

  // ****************************************
  // Charger detection combine
  // ****************************************
  wire low_setting;
  wire chg_raw;

  assign low_setting = (ichg_q == `CDL_ICHG_LOWEST) || (ichg_q == `CDL_ICHG_LOW);

  // Valid drop only counts as removal in the low-current or idle case
  assign chg_raw = (low_setting || !charging_active) ?
                   (charger_valid_cmp & charger_presence_cmp) :
                   (charger_presence_cmp | end_of_charge_current);

  // ****************************************
  // Debouncers
  // ****************************************
  wire [`CDL_NUM_CH-1:0] db_in;
  wire [`CDL_NUM_CH-1:0] db_out;
  wire [`CDL_NUM_CH-1:0] db_chg;

  assign db_in[`CDL_CH_CHG_DET]   = chg_raw;
  assign db_in[`CDL_CH_BMIN_FAST] = battery_minimum_level;
  assign db_in[`CDL_CH_BMIN_SLOW] = battery_minimum_level;
  assign db_in[`CDL_CH_BON_FAST]  = battery_operating_level;
  assign db_in[`CDL_CH_BON_SLOW]  = battery_operating_level;
  assign db_in[`CDL_CH_CCCV]      = cc_to_cv_transition_level;
  assign db_in[`CDL_CH_EOC]       = end_of_charge_current;

  // Period in ticks for a move to the high level
  function [`CDL_DB_CNT_W-1:0] rise_ticks;
    input integer ch;
    begin
      case (ch)
        `CDL_CH_CHG_DET:   rise_ticks = `CDL_DB_CHG_DET_MS / `CDL_TICK_MS;
        `CDL_CH_BMIN_FAST: rise_ticks = `CDL_DB_BATTERY_VOLTAGE_NODE_FAST_MS / `CDL_TICK_MS;
        `CDL_CH_BMIN_SLOW: rise_ticks = `CDL_DB_BATTERY_VOLTAGE_NODE_SLOW_MS / `CDL_TICK_MS;
        `CDL_CH_BON_FAST:  rise_ticks = `CDL_DB_BATTERY_VOLTAGE_NODE_FAST_MS / `CDL_TICK_MS;
        `CDL_CH_BON_SLOW:  rise_ticks = `CDL_DB_BATTERY_VOLTAGE_NODE_SLOW_MS / `CDL_TICK_MS;
        `CDL_CH_CCCV:      rise_ticks = `CDL_DB_CCCV_MS / `CDL_TICK_MS;
        default:           rise_ticks = `CDL_DB_EOC_MS / `CDL_TICK_MS;
      endcase
    end
  endfunction

  // Period in ticks for a move to the low level; none means at once
  function [`CDL_DB_CNT_W-1:0] fall_ticks;
    input integer ch;
    begin
      case (ch)
        `CDL_CH_CHG_DET:   fall_ticks = `CDL_DB_CHG_DET_MS / `CDL_TICK_MS;
        `CDL_CH_BMIN_FAST: fall_ticks = `CDL_DB_BMIN_FALL_MS / `CDL_TICK_MS;
        `CDL_CH_BMIN_SLOW: fall_ticks = `CDL_DB_BMIN_FALL_MS / `CDL_TICK_MS;
        `CDL_CH_BON_FAST:  fall_ticks = `CDL_DB_NONE;
        `CDL_CH_BON_SLOW:  fall_ticks = `CDL_DB_NONE;
        `CDL_CH_CCCV:      fall_ticks = `CDL_DB_CCCV_MS / `CDL_TICK_MS;
        default:           fall_ticks = `CDL_DB_EOC_MS / `CDL_TICK_MS;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CDL_NUM_CH; g = g + 1) begin : g_db
      reg  [`CDL_DB_CNT_W-1:0] cnt_q;
      reg                      out_q;
      reg                      chg_q;
      wire [`CDL_DB_CNT_W-1:0] per;
      wire [`CDL_DB_CNT_W-1:0] cnt_inc;

      assign per     = db_in[g] ? rise_ticks(g) : fall_ticks(g);
      assign cnt_inc = cnt_q + 1'b1;

      // Tick phase is free running, so the real wait is period minus up to one tick
      always @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= {`CDL_DB_CNT_W{1'b0}};
          out_q <= 1'b0;
          chg_q <= 1'b0;
        end else if (db_in[g] == out_q) begin
          cnt_q <= {`CDL_DB_CNT_W{1'b0}};
          chg_q <= 1'b0;
        end else if (per == `CDL_DB_NONE) begin
          out_q <= db_in[g];
          chg_q <= 1'b1;
        end else if (tick_q && (cnt_inc >= per)) begin
          cnt_q <= {`CDL_DB_CNT_W{1'b0}};
          out_q <= db_in[g];
          chg_q <= 1'b1;
        end else begin
          cnt_q <= tick_q ? cnt_inc : cnt_q;
          chg_q <= 1'b0;
        end
      end

      assign db_out[g] = out_q;
      assign db_chg[g] = chg_q;
    end
  endgenerate

  // Fast and slow copies are kept apart for the charger flow
  assign charger_detected        = db_out[`CDL_CH_CHG_DET];
  assign battery_minimum_fast    = db_out[`CDL_CH_BMIN_FAST];
  assign battery_minimum_slow    = db_out[`CDL_CH_BMIN_SLOW];
  assign battery_operating_fast  = db_out[`CDL_CH_BON_FAST];
  assign battery_operating_slow  = db_out[`CDL_CH_BON_SLOW];
  assign cc_to_cv_debounced      = db_out[`CDL_CH_CCCV];
  assign end_of_charge_debounced = db_out[`CDL_CH_EOC];

  // Crossing in either direction raises the event
  assign transition_interrupt    = db_chg[`CDL_CH_CCCV];
  assign end_of_charge_interrupt = db_chg[`CDL_CH_EOC];

  // ****************************************
  // Thermistor window and LED
  // ****************************************
  reg therm_q;
  reg led_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      therm_q <= 1'b0;
      led_q   <= 1'b0;
    end else begin
      therm_q <= thermistor_below_low_cmp & thermistor_above_high_cmp;
      if (sw_charge_q)
        led_q <= force_on_q;
      else
        led_q <= force_on_q | (charge_sm_running & ~charge_sm_done);
    end
  end

  assign thermistor_in_range   = therm_q;
  assign charge_indicator_sink = led_q;

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  reg                   aw_have_q;
  reg                   w_have_q;
  reg [`CDL_ADDR_W-1:0] aw_addr_q;
  reg [7:0]             w_data_q;
  reg                   w_lane0_q;
  reg                   bvalid_q;
  reg [1:0]             bresp_q;
  wire                  aw_take;
  wire                  w_take;
  wire                  do_write;
  wire                  wr_ctrl;
  wire                  wr_event;
  wire [1:0]            evt_set;
  wire [1:0]            evt_clr;

  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign do_write      = aw_have_q & w_have_q;
  assign wr_ctrl       = do_write & w_lane0_q & (aw_addr_q == `CDL_REG_CTRL);
  assign wr_event      = do_write & w_lane0_q & (aw_addr_q == `CDL_REG_EVENT);
  assign evt_set       = {db_chg[`CDL_CH_EOC], db_chg[`CDL_CH_CCCV]};
  assign evt_clr       = wr_event ? w_data_q[1:0] : 2'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q   <= 1'b0;
      w_have_q    <= 1'b0;
      aw_addr_q   <= {`CDL_ADDR_W{1'b0}};
      w_data_q    <= 8'h00;
      w_lane0_q   <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= `CDL_RESP_OKAY;
      force_on_q  <= 1'b0;
      sw_charge_q <= 1'b0;
      ichg_q      <= 4'h0;
      event_q     <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= ((aw_addr_q == `CDL_REG_CTRL) || (aw_addr_q == `CDL_REG_STATUS) ||
                      (aw_addr_q == `CDL_REG_EVENT)) ? `CDL_RESP_OKAY : `CDL_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (wr_ctrl) begin
        force_on_q  <= w_data_q[`CDL_CTRL_FORCE_BIT];
        sw_charge_q <= w_data_q[`CDL_CTRL_SWCHG_BIT];
        ichg_q      <= w_data_q[`CDL_CTRL_ICHG_MSB:`CDL_CTRL_ICHG_LSB];
      end
      // A new event in the clearing cycle stays set
      event_q <= (event_q & ~evt_clr) | evt_set;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;

  assign s_axi_arready = ~rvalid_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `CDL_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `CDL_RESP_OKAY;
      case (s_axi_araddr)
        `CDL_REG_CTRL:
          rdata_q <= {24'h00_0000, ichg_q, 2'h0, sw_charge_q, force_on_q};
        `CDL_REG_STATUS:
          rdata_q <= {23'h00_0000, led_q, therm_q, db_out};
        `CDL_REG_EVENT:
          rdata_q <= {30'h0000_0000, event_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `CDL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // cdl_charger_detect

// >>> dv/cdl_charger_detect_sva.sv
`timescale 1ns/1ps
// ****************************************
// Debounce and event checker
// ****************************************
module cdl_charger_detect_sva #(
  parameter TICK_CYCLES = 250000
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw comparators
  input wire battery_minimum_level,
  input wire battery_operating_level,
  input wire cc_to_cv_transition_level,
  input wire thermistor_below_low_cmp,
  input wire thermistor_above_high_cmp,
  // Debounced status and events
  input wire battery_minimum_fast,
  input wire battery_minimum_slow,
  input wire battery_operating_fast,
  input wire battery_operating_slow,
  input wire cc_to_cv_debounced,
  input wire end_of_charge_debounced,
  input wire thermistor_in_range,
  input wire transition_interrupt,
  input wire end_of_charge_interrupt
);
  localparam int T = TICK_CYCLES;
  // Cycles each raw level has held; saturates well past the slowest period
  logic [31:0] run_q [3];
  logic [2:0]  lvl_q;
  wire  [2:0]  lvl = {battery_minimum_level, battery_operating_level, cc_to_cv_transition_level};
  always @(posedge aclk) begin
    lvl_q <= lvl;
    for (int i = 0; i < 3; i++) begin
      if (!aresetn || lvl[i] != lvl_q[i])
        run_q[i] <= 32'h0000_0000;
      else if (run_q[i] != 32'hffff_ffff)
        run_q[i] <= run_q[i] + 32'h0000_0001;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  range_flag_a: assert property (
    1'b1 |=> thermistor_in_range == $past(thermistor_below_low_cmp && thermistor_above_high_cmp))
    else $error("thermistor flag wrong");
  cccv_event_a: assert property (
    1'b1 |-> transition_interrupt == $changed(cc_to_cv_debounced)) else $error("cccv event");
  eoc_event_a: assert property (
    1'b1 |-> end_of_charge_interrupt == $changed(end_of_charge_debounced)) else $error("eoc event");
  cccv_hold_a: assert property (
    $changed(cc_to_cv_debounced) |-> run_q[0] >= 99 * T) else $error("cccv moved early");
  cccv_follow_a: assert property (
    run_q[0] == 101 * T + 8 |-> cc_to_cv_debounced == cc_to_cv_transition_level)
    else $error("cccv never followed");
  bmin_rise_a: assert property (
    $rose(battery_minimum_fast) |-> run_q[2] >= 31 * T) else $error("bmin fast rose early");
  bmin_slow_a: assert property (
    $changed(battery_minimum_slow) || $fell(battery_minimum_fast) |-> run_q[2] >= 999 * T)
    else $error("bmin slow path early");
  bon_fast_a: assert property (
    run_q[1] == 33 * T + 8 && battery_operating_level |-> battery_operating_fast
    && !battery_operating_slow) else $error("bon outputs wrong");
  bon_fall_a: assert property (
    $fell(battery_operating_level) |-> ##[1:3] !battery_operating_fast && !battery_operating_slow)
    else $error("bon did not drop");
  cover property (transition_interrupt);
  cover property ($rose(battery_minimum_slow));
  cover property ($fell(battery_operating_fast));
endmodule // cdl_charger_detect_sva

bind cdl_charger_detect cdl_charger_detect_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .aclk, .aresetn, .battery_minimum_level, .battery_operating_level,
  .cc_to_cv_transition_level, .thermistor_below_low_cmp, .thermistor_above_high_cmp,
  .battery_minimum_fast, .battery_minimum_slow, .battery_operating_fast,
  .battery_operating_slow, .cc_to_cv_debounced, .end_of_charge_debounced,
  .thermistor_in_range, .transition_interrupt, .end_of_charge_interrupt
);

// >>> dv/cdl_pack_model.sv
`timescale 1ns/1ps
// ****************************************
// Charger, battery pack and thermistor
// ****************************************
// Thresholds are plain defaults, not trimmed figures
module cdl_pack_model #(
  parameter int VALID_MV = 3800,
  parameter int PRES_MV  = 30,
  parameter int CURR_MA  = 30,
  parameter int BMIN_MV  = 3000,
  parameter int BON_MV   = 3400
) (
  // Levels set by the bench
  input  int  raw_mv,
  input  int  drop_mv,
  input  int  cur_ma,
  input  int  bat_mv,
  input  int  cv_pct,
  input  int  therm_32,
  // Comparator outputs
  output wire charger_valid_cmp,
  output wire charger_presence_cmp,
  output wire end_of_charge_current,
  output wire battery_minimum_level,
  output wire battery_operating_level,
  output wire cc_to_cv_transition_level,
  output wire thermistor_below_low_cmp,
  output wire thermistor_above_high_cmp
);
  assign charger_valid_cmp         = raw_mv >= VALID_MV;
  assign charger_presence_cmp      = drop_mv >= PRES_MV;
  assign end_of_charge_current     = cur_ma >= CURR_MA;
  assign battery_minimum_level     = bat_mv >= BMIN_MV;
  assign battery_operating_level   = bat_mv >= BON_MV;
  assign cc_to_cv_transition_level = cv_pct >= 98;
  // Sense level counted in 32nds of the bias output
  assign thermistor_below_low_cmp  = therm_32 < 24;
  assign thermistor_above_high_cmp = therm_32 > 10;
endmodule // cdl_pack_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "cdl_defines.vh"
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %h, expected %h", $time, g, e); \
    end \
  end
module tb_top;
  // ****************************************
  // Wiring
  // ****************************************
  localparam int T = 4;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        charging_active = 1'b0, charge_sm_running = 1'b0, charge_sm_done = 1'b0;
  int          raw_mv = 0, drop_mv = 0, cur_ma = 0, bat_mv = 0, cv_pct = 0, therm_32 = 16;
  int          n_fail = 0, num_checks = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         charger_valid_cmp, charger_presence_cmp, end_of_charge_current;
  wire         battery_minimum_level, battery_operating_level, cc_to_cv_transition_level;
  wire         thermistor_below_low_cmp, thermistor_above_high_cmp, charger_detected;
  wire         battery_minimum_fast, battery_minimum_slow, battery_operating_fast;
  wire         battery_operating_slow, cc_to_cv_debounced, end_of_charge_debounced;
  wire         thermistor_in_range, transition_interrupt, end_of_charge_interrupt;
  wire         charge_indicator_sink;
  wire [3:0]   bat_o = {battery_minimum_fast, battery_minimum_slow,
                        battery_operating_fast, battery_operating_slow};
  // Setting, active, valid, presence, current, expected
  logic [8:0]  cd_tab [8] = '{9'h01d, 9'h016, 9'h03f, 9'h03a, 9'h055, 9'h1f8, 9'h053, 9'h046};
  // Software mode, force, running, done, expected
  logic [4:0]  led_tab [6] = '{5'h05, 5'h06, 5'h0f, 5'h00, 5'h14, 5'h19};
  int          th_v [6] = '{5, 10, 11, 23, 24, 30};
  logic [5:0]  th_e = 6'h0c;
  always #2 aclk = ~aclk;
  cdl_pack_model u_pack (
    .raw_mv, .drop_mv, .cur_ma, .bat_mv, .cv_pct, .therm_32,
    .charger_valid_cmp, .charger_presence_cmp, .end_of_charge_current,
    .battery_minimum_level, .battery_operating_level, .cc_to_cv_transition_level,
    .thermistor_below_low_cmp, .thermistor_above_high_cmp
  );
  // Response channels always accept, which leaves no ready path to exercise
  cdl_charger_detect #(.TICK_CYCLES(T)) u_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready(1'b1), .s_axi_rdata, .s_axi_rresp,
    .charger_valid_cmp, .charger_presence_cmp, .end_of_charge_current,
    .battery_minimum_level, .battery_operating_level, .cc_to_cv_transition_level,
    .thermistor_below_low_cmp, .thermistor_above_high_cmp, .charging_active,
    .charge_sm_running, .charge_sm_done, .charger_detected, .battery_minimum_fast,
    .battery_minimum_slow, .battery_operating_fast, .battery_operating_slow,
    .cc_to_cv_debounced, .end_of_charge_debounced, .thermistor_in_range,
    .transition_interrupt, .end_of_charge_interrupt, .charge_indicator_sink
  );
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n > 200) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic tk(input int n);
    repeat (n * T) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (aw && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
    end while (aw || w || !s_axi_bvalid);
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [3:0] a, input logic [8:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (!s_axi_rvalid);
    `CHK(s_axi_rdata, {23'h0, ed})
    `CHK(s_axi_rresp, er)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CDL_REG_CTRL, 9'h000, `CDL_RESP_OKAY);
    wr(`CDL_REG_STATUS, 32'h1ff, `CDL_RESP_OKAY);
    rd(`CDL_REG_STATUS, 9'h080, `CDL_RESP_OKAY);
    wr(4'hc, 32'h1, `CDL_RESP_SLVERR);
    rd(4'hc, 9'h000, `CDL_RESP_SLVERR);
    wr(`CDL_REG_CTRL, 32'hf3, `CDL_RESP_OKAY);
    rd(`CDL_REG_CTRL, 9'h0f3, `CDL_RESP_OKAY);
    // Lane 0 off: the write is answered but must leave the control bits alone
    s_axi_wstrb <= 4'he;
    wr(`CDL_REG_CTRL, 32'h0, `CDL_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`CDL_REG_CTRL, 9'h0f3, `CDL_RESP_OKAY);
    foreach (th_v[i]) begin
      therm_32 <= th_v[i];
      repeat (3) @(posedge aclk);
      `CHK(thermistor_in_range, th_e[i])
    end
    foreach (led_tab[k]) begin
      wr(`CDL_REG_CTRL, {30'h0, led_tab[k][4:3]}, `CDL_RESP_OKAY);
      charge_sm_running <= led_tab[k][2];
      charge_sm_done <= led_tab[k][1];
      repeat (3) @(posedge aclk);
      `CHK(charge_indicator_sink, led_tab[k][0])
    end
    foreach (cd_tab[k]) begin
      wr(`CDL_REG_CTRL, {24'h0, cd_tab[k][8:5], 4'h0}, `CDL_RESP_OKAY);
      charging_active <= cd_tab[k][4];
      raw_mv <= cd_tab[k][3] ? 5000 : 1000;
      drop_mv <= cd_tab[k][2] ? 100 : 0;
      cur_ma <= cd_tab[k][1] ? 100 : 0;
      tk(97);
      `CHK(charger_detected, ~cd_tab[k][0])
      tk(6);
      `CHK(charger_detected, cd_tab[k][0])
    end
    // A 60-tick blip toward insertion must be swallowed
    raw_mv <= 5000;
    tk(60);
    raw_mv <= 1000;
    tk(60);
    `CHK(charger_detected, 1'b0)
    wr(`CDL_REG_EVENT, 32'h3, `CDL_RESP_OKAY);
    rd(`CDL_REG_EVENT, 9'h000, `CDL_RESP_OKAY);
    cv_pct <= 99;
    tk(103);
    `CHK(cc_to_cv_debounced, 1'b1)
    rd(`CDL_REG_EVENT, 9'h001, `CDL_RESP_OKAY);
    wr(`CDL_REG_EVENT, 32'h1, `CDL_RESP_OKAY);
    cur_ma <= 0;
    tk(3);
    `CHK(end_of_charge_debounced, 1'b0)
    rd(`CDL_REG_EVENT, 9'h002, `CDL_RESP_OKAY);
    bat_mv <= 3600;
    tk(35);
    `CHK(bat_o, 4'ha)
    tk(968);
    `CHK(bat_o, 4'hf)
    bat_mv <= 2500;
    repeat (4) @(posedge aclk);
    `CHK(bat_o, 4'hc)
    tk(995);
    `CHK(bat_o, 4'hc)
    tk(8);
    `CHK(bat_o, 4'h0)
    tally_and_finish;
  end
endmodule // tb_top
